// file: cpt_consts.svh
`ifndef CPT_CONSTS_SVH
`define CPT_CONSTS_SVH

// register indices; byte address is four times the index
`define CPT_IDX_CH2_AMB_CONV_END   6'h10
`define CPT_IDX_CH1_CONV_START     6'h11
`define CPT_IDX_CH1_CONV_END       6'h12
`define CPT_IDX_CH1_AMB_CONV_START 6'h13
`define CPT_IDX_CH1_AMB_CONV_END   6'h14
`define CPT_IDX_RST0_START         6'h15
`define CPT_IDX_RST0_END           6'h16
`define CPT_IDX_RST1_START         6'h17
`define CPT_IDX_RST1_END           6'h18
`define CPT_IDX_RST2_START         6'h19
`define CPT_IDX_RST2_END           6'h1a
`define CPT_IDX_CONTROL            6'h1e
`define CPT_IDX_STATUS             6'h30

// count slots: slot = index - first index
`define CPT_IDX_FIRST              6'h10
`define CPT_IDX_LAST               6'h1a
`define CPT_NUM_COUNTS             11
`define CPT_COUNT_W                16
`define CPT_COUNT_RESET            16'h0000

// control and status fields
`define CPT_CTRL_RUN_BIT           8
`define CPT_STAT_RUN_BIT           16
`define CPT_STAT_COUNT_MSB         15

// timing
`define CPT_CLK_HZ                 20000000
`define CPT_TIMER_HZ               4000000
`define CPT_TICK_DIV               (`CPT_CLK_HZ / `CPT_TIMER_HZ)
`define CPT_PRESC_W                3

`endif

// file: cpt_pkg.sv
`include "cpt_consts.svh"

package cpt_pkg;

    typedef enum logic [1:0] {
        CPT_BUS_IDLE = 2'b01,
        CPT_BUS_ACK  = 2'b10
    } cpt_bus_state_t;

    typedef logic [`CPT_COUNT_W-1:0] cpt_count_t;

    typedef struct packed {
        cpt_bus_state_t                         bus;
        logic                                   ack;
        logic [31:0]                            rdata;
        logic                                   run;
        logic [`CPT_PRESC_W-1:0]                presc;
        logic                                   tick;
        cpt_count_t                             count;
        logic                                   c2end;
        logic [`CPT_NUM_COUNTS-1:0][`CPT_COUNT_W-1:0] cnt;
    } cpt_state_t;

    typedef struct packed {
        logic active;
    } cpt_win_state_t;

endpackage

// file: cpt_phase_if.sv
`include "cpt_consts.svh"

interface cpt_phase_if;
    logic                    run;
    logic [`CPT_COUNT_W-1:0] count;
    logic [`CPT_COUNT_W-1:0] start_cnt;
    logic [`CPT_COUNT_W-1:0] end_cnt;
    logic                    active;

    modport timer  (output run, count, start_cnt, end_cnt, input active);
    modport window (input run, count, start_cnt, end_cnt, output active);
endinterface

// file: cpt_phase_window.sv
`include "cpt_consts.svh"

module cpt_phase_window (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    cpt_phase_if.window        ph
);
    cpt_pkg::cpt_win_state_t st_r;
    cpt_pkg::cpt_win_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!ph.run) begin
            st_nxt.active = 1'b0;
        end else if (ph.count == ph.end_cnt) begin
            // end wins when start and end coincide: no zero-width glitch
            st_nxt.active = 1'b0;
        end else if (ph.count == ph.start_cnt) begin
            st_nxt.active = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ph.active = st_r.active;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    phase_rise_a: assert property (
        ph.run && ph.count == ph.start_cnt && ph.count != ph.end_cnt
        |=> ph.active)
        else $error("phase not raised at start count");
    phase_fall_a: assert property (
        ph.run && ph.count == ph.end_cnt |=> !ph.active)
        else $error("phase not dropped at end count");
endmodule

// file: cpt_timer.sv
// Design decision made here: register access over Wishbone.
`include "cpt_consts.svh"

module cpt_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    input  wire logic [15:0] repetition_period_length_i,
    output wire logic [15:0] period_count_o,
    output wire logic        timer_tick_o,
    output wire logic        timer_run_enable_o,
    output wire logic        chan1_conv_o,
    output wire logic        chan1_amb_conv_o,
    output wire logic [2:0]  conv_reset_o,
    output wire logic        chan2_amb_conv_end_o
);
    localparam int NUM_WIN = 5;

    cpt_pkg::cpt_state_t st_r;
    cpt_pkg::cpt_state_t st_nxt;

    logic [5:0]        idx;
    logic              in_counts;
    logic [3:0]        slot;
    logic [31:0]       rd_word;
    logic [NUM_WIN-1:0] win_active;

    assign idx       = wb_adr_i[7:2];
    assign in_counts = (idx >= `CPT_IDX_FIRST) && (idx <= `CPT_IDX_LAST);
    assign slot      = 4'(idx - `CPT_IDX_FIRST);

    // read data: counts occupy bits 15:0; above that only the status run bit 16 can read non-zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_counts) begin
            rd_word[15:0] = st_r.cnt[slot];
        end else if (idx == `CPT_IDX_CONTROL) begin
            rd_word[`CPT_CTRL_RUN_BIT] = st_r.run;
        end else if (idx == `CPT_IDX_STATUS) begin
            rd_word[`CPT_STAT_COUNT_MSB:0] = st_r.count;
            rd_word[`CPT_STAT_RUN_BIT]     = st_r.run;
        end
    end

    always_comb begin
        st_nxt       = st_r;
        st_nxt.ack   = 1'b0;
        st_nxt.tick  = 1'b0;
        st_nxt.c2end = 1'b0;

        // bus: answer one cycle after the request, commit on the ack edge
        case (st_r.bus)
            cpt_pkg::CPT_BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    st_nxt.ack   = 1'b1;
                    st_nxt.rdata = rd_word;
                    st_nxt.bus   = cpt_pkg::CPT_BUS_ACK;
                end
            end
            cpt_pkg::CPT_BUS_ACK: begin
                st_nxt.bus = cpt_pkg::CPT_BUS_IDLE;
                if (wb_cyc_i && wb_stb_i && wb_we_i) begin
                    // bits 31:16 are not stored: software keeps them zero
                    if (in_counts) begin
                        if (wb_sel_i[0]) begin
                            st_nxt.cnt[slot][7:0] = wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            st_nxt.cnt[slot][15:8] = wb_dat_i[15:8];
                        end
                    end else if (idx == `CPT_IDX_CONTROL && wb_sel_i[1]) begin
                        st_nxt.run = wb_dat_i[`CPT_CTRL_RUN_BIT];
                    end
                end
            end
            default: begin
                st_nxt.bus = cpt_pkg::CPT_BUS_IDLE;
            end
        endcase

        // period counter: one step per 4-MHz tick derived from clk_i
        if (!st_r.run) begin
            st_nxt.presc = '0;
            st_nxt.count = '0;
        end else if (st_r.presc == `CPT_PRESC_W'(`CPT_TICK_DIV - 1)) begin
            st_nxt.presc = '0;
            st_nxt.tick  = 1'b1;
            // period length is trusted to lie in the legal range
            if (st_r.count >= repetition_period_length_i) begin
                st_nxt.count = '0;
            end else begin
                st_nxt.count = st_r.count + 16'h0001;
            end
        end else begin
            st_nxt.presc = st_r.presc + `CPT_PRESC_W'(1);
        end

        // first clk of each count value, so the pulse is one cycle wide
        st_nxt.c2end = st_r.run && (st_r.presc == '0)
                       && (st_r.count == st_r.cnt[0]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r     <= '0;
            st_r.bus <= cpt_pkg::CPT_BUS_IDLE;
            st_r.cnt <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // window w uses slots 2w+1 (start) and 2w+2 (end)
    genvar w;
    generate
        for (w = 0; w < NUM_WIN; w++) begin : g_win
            cpt_phase_if ph ();
            assign ph.run       = st_r.run;
            assign ph.count     = st_r.count;
            assign ph.start_cnt = st_r.cnt[2*w+1];
            assign ph.end_cnt   = st_r.cnt[2*w+2];
            assign win_active[w] = ph.active;
            cpt_phase_window u_win (
                .clk_i (clk_i),
                .rst_i (rst_i),
                .ph    (ph)
            );
        end
    endgenerate

    assign wb_dat_o             = st_r.rdata;
    assign wb_ack_o             = st_r.ack;
    assign period_count_o       = st_r.count;
    assign timer_tick_o         = st_r.tick;
    assign timer_run_enable_o   = st_r.run;
    assign chan1_conv_o         = win_active[0];
    assign chan1_amb_conv_o     = win_active[1];
    assign conv_reset_o         = win_active[4:2];
    assign chan2_amb_conv_end_o = st_r.c2end;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req_new;
        wb_cyc_i && wb_stb_i && !wb_ack_o && st_r.bus == cpt_pkg::CPT_BUS_IDLE;
    endsequence

    sequence s_tick_gap;
        (!st_r.tick) [*4];
    endsequence

    bus_ack_timing_a: assert property (
        s_req_new |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");

    read_upper_zero_a: assert property (
        wb_ack_o && !$past(wb_we_i) && idx != `CPT_IDX_STATUS
        |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper bits not zero");

    count_write_a: assert property (
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && in_counts
        && wb_sel_i[1:0] == 2'b11
        |=> st_r.cnt[$past(slot)] == $past(wb_dat_i[15:0]))
        else $error("count register did not take written value");

    reset_zero_a: assert property (
        $past(rst_i) |-> st_r.cnt == '0 && !st_r.run)
        else $error("counts not zero after reset");

    stopped_idle_a: assert property (
        !st_r.run ##1 !st_r.run |-> st_r.count == 16'h0000
        && !st_r.tick ##1 win_active == '0)
        else $error("timer active while run enable clear");

    tick_spacing_a: assert property (
        st_r.tick |=> s_tick_gap ##1 (st_r.tick || !$past(st_r.run)))
        else $error("tick spacing not five clocks");

    period_wrap_a: assert property (
        st_r.run && st_nxt.tick
        && st_r.count >= repetition_period_length_i
        |=> st_r.count == 16'h0000)
        else $error("period counter did not wrap");

    chan2_end_a: assert property (
        st_r.run && st_r.presc == '0 && st_r.count == st_r.cnt[0]
        |=> chan2_amb_conv_end_o ##1 !chan2_amb_conv_end_o)
        else $error("channel-2 ambient end pulse missing");

    // accesses as seen at the ack edge; the master still holds the
    // request there, so address and lanes are those of the access
    sequence s_ack_read;
        wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
    endsequence

    sequence s_count_write;
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && in_counts;
    endsequence

    sequence s_ctrl_write;
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
        && idx == `CPT_IDX_CONTROL && wb_sel_i[1];
    endsequence

    // bus handshake
    ack_has_req_a: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack given without a request");

    ack_drop_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    bus_state_a: assert property (
        $onehot(st_r.bus)
        && wb_ack_o == (st_r.bus == cpt_pkg::CPT_BUS_ACK))
        else $error("bus state illegal or out of step with ack");

    // read data is held between answers so a slow master still sees it
    rdata_hold_a: assert property (
        !wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved between answers");

    reset_outputs_a: assert property (
        $past(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0000_0000
        && !chan2_amb_conv_end_o && win_active == '0)
        else $error("outputs not idle after reset");

    // read-back of every register
    read_count_a: assert property (
        s_ack_read ##0 in_counts
        |-> wb_dat_o == {16'h0000, st_r.cnt[slot]})
        else $error("count read-back differs from stored count");

    read_ctrl_a: assert property (
        s_ack_read ##0 idx == `CPT_IDX_CONTROL
        |-> wb_dat_o[31:9] == '0 && wb_dat_o[8] == st_r.run
        && wb_dat_o[7:0] == 8'h00)
        else $error("control read-back wrong");

    read_status_a: assert property (
        s_ack_read ##0 idx == `CPT_IDX_STATUS
        |-> wb_dat_o[31:17] == '0 && wb_dat_o[16] == st_r.run)
        else $error("status read-back wrong");

    read_unmapped_a: assert property (
        s_ack_read ##0 !in_counts && idx != `CPT_IDX_CONTROL
        && idx != `CPT_IDX_STATUS
        |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped index did not read zero");

    // lanes are independent so software may update one byte of a count
    run_write_a: assert property (
        s_ctrl_write
        |=> st_r.run == $past(wb_dat_i[`CPT_CTRL_RUN_BIT]))
        else $error("run enable did not take written value");

    regs_stable_a: assert property (
        !(wb_ack_o && wb_we_i) |=> $stable(st_r.cnt) && $stable(st_r.run))
        else $error("register changed without a write");

    lane_take_low_a: assert property (
        s_count_write ##0 wb_sel_i[0]
        |=> st_r.cnt[$past(slot)][7:0] == $past(wb_dat_i[7:0]))
        else $error("low byte lane not written");

    lane_take_high_a: assert property (
        s_count_write ##0 wb_sel_i[1]
        |=> st_r.cnt[$past(slot)][15:8] == $past(wb_dat_i[15:8]))
        else $error("high byte lane not written");

    lane_keep_low_a: assert property (
        s_count_write ##0 !wb_sel_i[0]
        |=> st_r.cnt[$past(slot)][7:0] == $past(st_r.cnt[slot][7:0]))
        else $error("unselected low byte lane changed");

    lane_keep_high_a: assert property (
        s_count_write ##0 !wb_sel_i[1]
        |=> st_r.cnt[$past(slot)][15:8] == $past(st_r.cnt[slot][15:8]))
        else $error("unselected high byte lane changed");

    // the length input is only compared, so a length moved below the
    // count makes the counter wrap at the next tick
    presc_range_a: assert property (
        st_r.presc <= `CPT_PRESC_W'(`CPT_TICK_DIV - 1))
        else $error("prescaler beyond its last step");

    tick_presc_a: assert property (
        st_r.tick |-> st_r.presc == '0 && $past(st_r.run))
        else $error("tick without a fresh prescaler cycle");

    count_step_a: assert property (
        st_r.run && st_nxt.tick
        && st_r.count < repetition_period_length_i
        |=> st_r.count == $past(st_r.count) + 16'h0001)
        else $error("period counter did not step on tick");

    count_hold_a: assert property (
        st_r.run && !st_nxt.tick |=> $stable(st_r.count))
        else $error("period counter moved between ticks");

    run_start_a: assert property (
        $rose(st_r.run) |-> st_r.count == 16'h0000 && st_r.presc == '0)
        else $error("period counter not at zero when run starts");

    stop_clear_a: assert property (
        !st_r.run |=> st_r.count == 16'h0000 && st_r.presc == '0
        && !st_r.tick && !chan2_amb_conv_end_o)
        else $error("timer not held while run enable clear");

    // window outputs are registered, so they follow run one clock late, hence the next-cycle check
    phases_off_a: assert property (
        !st_r.run |=> win_active == '0)
        else $error("phase output on while run enable clear");

    // the end pulse comes only from a fresh match at the end count
    c2end_cause_a: assert property (
        chan2_amb_conv_end_o
        |-> $past(st_r.run) && $past(st_r.presc) == '0
        && $past(st_r.count) == $past(st_r.cnt[0]))
        else $error("end pulse without a fresh end-count match");

    c2end_single_a: assert property (
        chan2_amb_conv_end_o |=> !chan2_amb_conv_end_o)
        else $error("end pulse longer than one clock");
endmodule

// file: cpt_timer_test.sv
`include "cpt_consts.svh"

module cpt_timer_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] wdat  = 32'h0000_0000;
    logic [15:0] len   = 16'h0000;
    logic [31:0] q;
    logic [3:0]  lanes = 4'hf;
    wire  logic [31:0] rdat;
    wire  logic        ack;
    wire  logic [15:0] pcnt;
    wire  logic        tick;
    wire  logic        run;
    wire  logic        c1;
    wire  logic        c1a;
    wire  logic [2:0]  crst;
    wire  logic        c2e;
    int          err_total   = 0;
    int          check_count = 0;
    bit          mon = 1'b0;
    logic [4:0]  win;
    logic [15:0] prev;
    logic [15:0] prev2;
    int          gap;
    bit          seen;
    // slot 0 is the channel-2 end; then start/end pairs of five windows
    // reset 2 window spans the wrap so the counter reset is exercised
    logic [15:0] vals [11] = '{16'h0007, 16'h0003, 16'h0006, 16'h0008,
        16'h000a, 16'h0001, 16'h0002, 16'h0005, 16'h0005, 16'h031f,
        16'h0002};

    cpt_timer DUT (
        .clk_i                      (clk_i),
        .rst_i                      (rst_i),
        .wb_cyc_i                   (cyc),
        .wb_stb_i                   (stb),
        .wb_we_i                    (we),
        .wb_adr_i                   (adr),
        .wb_sel_i                   (sel),
        .wb_dat_i                   (wdat),
        .wb_dat_o                   (rdat),
        .wb_ack_o                   (ack),
        .repetition_period_length_i (len),
        .period_count_o             (pcnt),
        .timer_tick_o               (tick),
        .timer_run_enable_o         (run),
        .chan1_conv_o               (c1),
        .chan1_amb_conv_o           (c1a),
        .conv_reset_o               (crst),
        .chan2_amb_conv_end_o       (c2e)
    );

    always #25 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] idx,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= d;
        sel  <= lanes;
        // no limit here: a missing ack is caught by the watchdog
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // reference for counter, windows and end pulse, one step per clock
    always @(negedge clk_i) begin
        if (mon && run === 1'b1) begin
            gap++;
            for (int i = 0; i < 5; i++) begin
                if (prev == vals[2+2*i]) win[i] = 1'b0;
                else if (prev == vals[1+2*i]) win[i] = 1'b1;
            end
            chk(pcnt, tick ? ((prev >= len) ? 0 : prev + 1) : prev);
            chk({crst, c1a, c1}, win);
            chk(c2e, prev == vals[0] && prev2 != vals[0]);
            if (tick === 1'b1) begin
                if (seen) chk(gap, `CPT_TICK_DIV);
                gap  = 0;
                seen = 1'b1;
            end
            prev2 = prev;
            prev  = pcnt;
        end else begin
            win   = '0;
            prev  = '0;
            prev2 = '0;
            gap   = 0;
            seen  = 1'b0;
        end
    end

    initial begin
        #(50 * 20000);
        err_total++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, 6'h10 + 6'(i), 32'h0, q);
            chk(q, 32'h0);
        end
        bus(1'b0, `CPT_IDX_CONTROL, 32'h0, q);
        chk(q, 32'h0);
        chk({pcnt, crst, c1a, c1, c2e, run}, 32'h0);
        for (int i = 0; i < 11; i++) begin
            bus(1'b1, 6'h10 + 6'(i), {16'h0000, vals[i]}, q);
        end
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, 6'h10 + 6'(i), 32'h0, q);
            chk(q, {16'h0000, vals[i]});
        end
        // single byte lanes: the other byte of the count must be kept
        lanes = 4'h2;
        bus(1'b1, `CPT_IDX_RST2_END, 32'h0000_ab34, q);
        bus(1'b0, `CPT_IDX_RST2_END, 32'h0, q);
        chk(q, 32'h0000_ab02);
        lanes = 4'h1;
        bus(1'b1, `CPT_IDX_RST2_END, 32'h0000_ff99, q);
        bus(1'b0, `CPT_IDX_RST2_END, 32'h0, q);
        chk(q, 32'h0000_ab99);
        lanes = 4'hf;
        bus(1'b1, `CPT_IDX_RST2_END, {16'h0000, vals[10]}, q);
        bus(1'b0, `CPT_IDX_RST2_END, 32'h0, q);
        chk(q, {16'h0000, vals[10]});
        bus(1'b0, 6'h3c, 32'h0, q);
        chk(q, 32'h0);
        len <= 16'd800;
        bus(1'b1, `CPT_IDX_CONTROL, 32'h0000_0100, q);
        mon = 1'b1;
        bus(1'b0, `CPT_IDX_CONTROL, 32'h0, q);
        chk(q, 32'h0000_0100);
        bus(1'b0, `CPT_IDX_STATUS, 32'h0, q);
        chk(q & 32'hffff_0000, 32'h0001_0000);
        // a little over two periods, so both wraps are seen
        repeat (8300) @(posedge clk_i);
        mon = 1'b0;
        bus(1'b1, `CPT_IDX_CONTROL, 32'h0, q);
        repeat (10) @(posedge clk_i);
        chk({pcnt, crst, c1a, c1, c2e, run, tick}, 32'h0);
        conclude();
    end
endmodule
